// ---- core/usb_suspend_resume_power_ctrl.sv ----
// Suspend detection, wake-up, remote wake-up and regulator power sequencing.
// Assumes bus line states come from the transceiver as async pins; firmware
// control bits come from synchronous register logic outside this block.
`timescale 1ns/1ps
`default_nettype none
module usb_suspend_resume_power_ctrl
	import pwr_seq_pkg::*;
#(
	parameter int IDLE_CYC  = IDLE_SUSP_CYC,
	parameter int DWELL_CYC = SUSP_DWELL_CYC,
	parameter int RESUM_CYC = RESUME_DONE_CYC,
	parameter int RDLY_CYC  = RWAKE_DELAY_CYC,
	parameter int RK_CYC    = RWAKE_K_CYC,
	parameter int LOCK_CYC  = PLL_LOCK_CYC,
	parameter int PORP_CYC  = POR_CYC
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             sof_seen,
	input  wire logic             bus_activity,
	input  wire logic             bus_k_state,
	input  wire logic             chip_select_n,
	input  wire logic             read_strobe_n,
	input  wire logic             ref_freq_sel_a,
	input  wire logic             ref_freq_sel_b,
	input  wire logic             downstream_wake,
	input  wire logic             vbus_overcurrent,
	input  wire logic             go_suspend,
	input  wire logic             send_resume,
	input  wire logic             chip_select_wake_en,
	input  wire logic             suspend_irq_en,
	input  wire logic             resume_irq_en,
	input  wire logic             regulator_power_on,
	input  wire logic             regulator_suspend_power,
	input  wire logic             unlock_cmd,
	input  wire logic [ST_W-1:0]  status_clr,
	output logic [ST_W-1:0]       periph_irq_status,
	output logic                  irq_out,
	output logic                  bus_k_drive,
	output logic                  osc_pll_en,
	output logic                  periph_clk_en,
	output logic                  host_clk_en,
	output logic                  regulator_en,
	output logic                  regulator_susp,
	output logic                  por_reset,
	output logic                  suspended,
	output logic                  write_protect,
	output logic [1:0]            ref_select
);
	localparam logic [CNT_W-1:0] IDLE_N  = CNT_W'(IDLE_CYC);
	localparam logic [CNT_W-1:0] DWELL_N = CNT_W'(DWELL_CYC);
	localparam logic [CNT_W-1:0] RESUM_N = CNT_W'(RESUM_CYC);
	localparam logic [CNT_W-1:0] RDLY_N  = CNT_W'(RDLY_CYC);
	localparam logic [CNT_W-1:0] RK_N    = CNT_W'(RK_CYC);
	localparam logic [CNT_W-1:0] LOCK_N  = CNT_W'(LOCK_CYC);
	localparam logic [CNT_W-1:0] POR_N   = CNT_W'(PORP_CYC);

	// Two-flop synchronisers for pins: sof, act, k, cs_n, rd_n, sel a/b, dsw, oc
	localparam int NS = 9;
	localparam logic [NS-1:0] SYNC_IDLE = 9'h018; // Rest levels, so reset fakes no event
	logic [NS-1:0] s1_q, s2_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= SYNC_IDLE;
			s2_q <= SYNC_IDLE;
		end else begin
			s1_q <= {vbus_overcurrent, downstream_wake, ref_freq_sel_b, ref_freq_sel_a,
				read_strobe_n, chip_select_n, bus_k_state, bus_activity, sof_seen};
			s2_q <= s1_q;
		end
	end
	logic sof_s, act_s, k_s, cs_n_s, rd_n_s, sel_a_s, sel_b_s, dsw_s, oc_s;
	assign {oc_s, dsw_s, sel_b_s, sel_a_s, rd_n_s, cs_n_s, k_s, act_s, sof_s} = s2_q;

	logic dummy_read;
	assign dummy_read = !cs_n_s && !rd_n_s;

	// Firmware bit edges
	logic go_susp_q, send_res_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			go_susp_q  <= 1'b0;
			send_res_q <= 1'b0;
		end else begin
			go_susp_q  <= go_suspend;
			send_res_q <= send_resume;
		end
	end
	logic go_susp_fall, send_res_fall;
	assign go_susp_fall  = go_susp_q && !go_suspend;
	assign send_res_fall = send_res_q && !send_resume;

	pwr_state_t   st_q;
	rwake_state_t rw_q;
	logic         dwell_done_q;

	// Idle timer: restarts on any activity
	logic idle_busy, idle_done;
	logic idle_restart;
	assign idle_restart = sof_s || act_s || k_s || st_q != P_RUN;
	cycle_timer u_idle (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (idle_restart || !idle_busy),
		.count (IDLE_N),
		.clr   (1'b0),
		.busy  (idle_busy),
		.done  (idle_done)
	);
	logic idle_fired_q;
	logic susp_event;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_fired_q <= 1'b0;
		end else if (idle_restart) begin
			idle_fired_q <= 1'b0;
		end else if (idle_done) begin
			idle_fired_q <= 1'b1;
		end
	end
	// Flag only once per uninterrupted idle period
	assign susp_event = idle_done && !idle_fired_q;

	// Shared sequence timer for POR, dwell and PLL lock; resume window has its own timer
	logic       seq_load, seq_busy, seq_done;
	logic [CNT_W-1:0] seq_count;
	cycle_timer u_seq (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (seq_load),
		.count (seq_count),
		.clr   (1'b0),
		.busy  (seq_busy),
		.done  (seq_done)
	);

	logic res_busy, res_done, res_load;
	cycle_timer u_res (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (res_load),
		.count (RESUM_N),
		.clr   (1'b0),
		.busy  (res_busy),
		.done  (res_done)
	);

	logic wake_req, low_pwr_wake, enter_deep, pwr_off;
	assign wake_req = k_s || (chip_select_wake_en && dummy_read);
	assign low_pwr_wake = dummy_read || dsw_s || oc_s || k_s;
	assign enter_deep = regulator_power_on && regulator_suspend_power;
	assign pwr_off = !regulator_power_on;

	logic resume_event;
	assign resume_event = (st_q == P_SUSP) && dwell_done_q && wake_req;

	always_comb begin
		seq_load  = 1'b0;
		seq_count = POR_N;
		res_load  = 1'b0;
		case (st_q)
			P_OFF: begin
				if (dummy_read) begin
					seq_load  = 1'b1;
					seq_count = POR_N;
				end
			end
			P_RUN: begin
				if (go_susp_fall) begin
					seq_load  = 1'b1;
					seq_count = DWELL_N;
				end
			end
			P_SUSP: begin
				if (resume_event) begin
					seq_load  = 1'b1;
					seq_count = LOCK_N;
					res_load  = 1'b1;
				end
			end
			P_DEEP: begin
				if (low_pwr_wake) begin
					seq_load  = 1'b1;
					seq_count = LOCK_N;
					res_load  = 1'b1;
				end
			end
			default: seq_load = 1'b0;
		endcase
	end

	// Power-mode state machine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= P_OFF;
		end else if (pwr_off && st_q != P_OFF && st_q != P_POR) begin
			st_q <= P_OFF;
		end else begin
			case (st_q)
				P_OFF: if (dummy_read) st_q <= P_POR;
				P_POR: if (seq_done) st_q <= P_RUN;
				P_RUN: begin
					if (enter_deep) st_q <= P_DEEP;
					else if (go_susp_fall) st_q <= P_SUSP;
				end
				P_SUSP: begin
					if (enter_deep) st_q <= P_DEEP;
					else if (resume_event) st_q <= P_WAKE;
				end
				P_WAKE: if (res_done) st_q <= P_RUN;
				P_DEEP: if (low_pwr_wake) st_q <= P_WAKE;
				default: st_q <= P_OFF;
			endcase
		end
	end

	// Dwell expiry gates wake response
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dwell_done_q <= 1'b0;
		end else if (st_q != P_SUSP) begin
			dwell_done_q <= 1'b0;
		end else if (seq_done) begin
			dwell_done_q <= 1'b1;
		end
	end

	// Clock gating: peripheral clocks only after PLL lock
	logic lock_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_q <= 1'b0;
		end else if (st_q == P_WAKE && seq_done) begin
			lock_q <= 1'b1;
		end else if (st_q != P_WAKE) begin
			lock_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_pll_en     <= 1'b0;
			periph_clk_en  <= 1'b0;
			host_clk_en    <= 1'b0;
			regulator_en   <= 1'b0;
			regulator_susp <= 1'b0;
			por_reset      <= 1'b1;
			suspended      <= 1'b0;
		end else begin
			osc_pll_en     <= st_q == P_RUN || st_q == P_WAKE || st_q == P_POR;
			periph_clk_en  <= st_q == P_RUN || (st_q == P_WAKE && lock_q);
			host_clk_en    <= st_q == P_RUN || st_q == P_SUSP || (st_q == P_WAKE && lock_q);
			regulator_en   <= st_q != P_OFF;
			regulator_susp <= st_q == P_DEEP;
			por_reset      <= st_q == P_OFF || st_q == P_POR;
			suspended      <= st_q == P_SUSP || st_q == P_DEEP || st_q == P_WAKE;
		end
	end

	// Status flags: set wins over write-one clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_irq_status <= '0;
		end else begin
			periph_irq_status[ST_SUSP] <= susp_event ||
				(periph_irq_status[ST_SUSP] && !status_clr[ST_SUSP]);
			periph_irq_status[ST_RESUME] <= resume_event ||
				(periph_irq_status[ST_RESUME] && !status_clr[ST_RESUME]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= (periph_irq_status[ST_SUSP] && suspend_irq_en) ||
				(periph_irq_status[ST_RESUME] && resume_irq_en);
		end
	end

	// Write protection from resume until unlock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_protect <= 1'b0;
		end else if (resume_event) begin
			write_protect <= 1'b1;
		end else if (unlock_cmd) begin
			write_protect <= 1'b0;
		end
	end

	// Remote wake-up K-state generator
	logic rw_load, rw_busy, rw_done;
	logic [CNT_W-1:0] rw_count;
	assign rw_load = (rw_q == R_IDLE && send_res_fall) || (rw_q == R_DELAY && rw_done);
	assign rw_count = (rw_q == R_IDLE) ? RDLY_N : RK_N;
	cycle_timer u_rw (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (rw_load),
		.count (rw_count),
		.clr   (1'b0),
		.busy  (rw_busy),
		.done  (rw_done)
	);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rw_q <= R_IDLE;
		end else begin
			case (rw_q)
				R_IDLE:  if (send_res_fall) rw_q <= R_DELAY;
				R_DELAY: if (rw_done) rw_q <= R_DRIVE;
				R_DRIVE: if (rw_done) rw_q <= R_IDLE;
				default: rw_q <= R_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_k_drive <= 1'b0;
		end else begin
			bus_k_drive <= (rw_q == R_DELAY && rw_done) || (rw_q == R_DRIVE && !rw_done);
		end
	end

	// Reference frequency select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_select <= REF_SEL_12M;
		end else begin
			case ({sel_b_s, sel_a_s})
				REF_12M:  ref_select <= REF_SEL_12M;
				REF_19M2: ref_select <= REF_SEL_19M2;
				REF_24M:  ref_select <= REF_SEL_24M;
				default:  ref_select <= REF_SEL_24M;
			endcase
		end
	end

	logic unused_ok;
	assign unused_ok = seq_busy ^ res_busy ^ rw_busy;
endmodule
`default_nettype wire

// ---- core/pwr_seq_pkg.sv ----
// Constants for the suspend, resume and power-mode sequencer.
// Assumes a 25 MHz core clock; times are converted to cycle counts here.
package pwr_seq_pkg;
	localparam int CLK_HZ          = 25000000;
	localparam int IDLE_SUSP_US    = 3000;
	localparam int SUSP_DWELL_US   = 5000;
	localparam int RESUME_DONE_US  = 5000;
	localparam int RWAKE_DELAY_US  = 5000;
	localparam int RWAKE_K_US      = 10000;
	localparam int PLL_LOCK_US     = 100;
	localparam int POR_US          = 100;
	localparam int IDLE_SUSP_CYC   = IDLE_SUSP_US * (CLK_HZ / 1000000);
	localparam int SUSP_DWELL_CYC  = SUSP_DWELL_US * (CLK_HZ / 1000000);
	localparam int RESUME_DONE_CYC = RESUME_DONE_US * (CLK_HZ / 1000000);
	localparam int RWAKE_DELAY_CYC = RWAKE_DELAY_US * (CLK_HZ / 1000000);
	localparam int RWAKE_K_CYC     = RWAKE_K_US * (CLK_HZ / 1000000);
	localparam int PLL_LOCK_CYC    = PLL_LOCK_US * (CLK_HZ / 1000000);
	localparam int POR_CYC         = POR_US * (CLK_HZ / 1000000);
	localparam int CNT_W           = 20;
	// Status bit positions in periph_irq_status
	localparam int ST_SUSP         = 0;
	localparam int ST_RESUME       = 1;
	localparam int ST_W            = 2;
	// Reference select codes {ref_freq_sel_b, ref_freq_sel_a}
	localparam logic [1:0] REF_12M   = 2'h0;
	localparam logic [1:0] REF_19M2  = 2'h1;
	localparam logic [1:0] REF_24M   = 2'h2;
	localparam logic [1:0] REF_SEL_12M  = 2'h0;
	localparam logic [1:0] REF_SEL_19M2 = 2'h1;
	localparam logic [1:0] REF_SEL_24M  = 2'h2;
	typedef enum logic [2:0] {P_OFF, P_POR, P_RUN, P_SUSP, P_WAKE, P_DEEP} pwr_state_t;
	typedef enum logic [1:0] {R_IDLE, R_DELAY, R_DRIVE} rwake_state_t;
endpackage

// ---- core/cycle_timer.sv ----
// Loadable down-counter; done pulses one cycle when the count expires.
// Assumes load and clr come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
	import pwr_seq_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	input  wire logic         clr,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (clr) begin
				busy <= 1'b0;
			end else if (load) begin
				cnt_q <= count;
				busy  <= 1'b1;
			end else if (busy) begin
				if (cnt_q <= W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - W'(1);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/host_model.sv ----
// USB host stand-in: frame markers, other traffic and resume K-state.
// Assumes the bench raises its requests on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  sof_on,
	input  wire logic  act_on,
	input  wire logic  k_on,
	input  wire logic  bus_k_drive,
	output logic       sof_seen,
	output logic       bus_activity,
	output logic       bus_k_state,
	output logic [15:0] k_len
);
	logic [2:0] frame_q;
	// One marker every eight cycles while frames run
	assign sof_seen = sof_on && (frame_q == 3'h0);
	assign bus_activity = act_on;
	assign bus_k_state = k_on;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_q <= 3'h0;
		end else begin
			frame_q <= frame_q + 3'h1;
		end
	end
	// Total K time driven by the device; one remote wake per run
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			k_len <= 16'h0;
		end else if (bus_k_drive) begin
			k_len <= k_len + 16'h1;
		end
	end
endmodule
`default_nettype wire

// ---- dv/usb_suspend_resume_power_ctrl_asserts.sv ----
// Port-level checker for the power sequencer.
// Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_chk
	import pwr_seq_pkg::*;
#(
	parameter int DWELL_CYC = 30
) (
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            send_resume,
	input wire logic            suspend_irq_en,
	input wire logic            resume_irq_en,
	input wire logic            regulator_power_on,
	input wire logic            unlock_cmd,
	input wire logic [ST_W-1:0] status_clr,
	input wire logic [ST_W-1:0] periph_irq_status,
	input wire logic            irq_out,
	input wire logic            bus_k_drive,
	input wire logic            osc_pll_en,
	input wire logic            periph_clk_en,
	input wire logic            host_clk_en,
	input wire logic            regulator_en,
	input wire logic            regulator_susp,
	input wire logic            por_reset,
	input wire logic            suspended,
	input wire logic            write_protect
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [19:0] sus_cnt_q;
	logic        irq_src;
	assign irq_src = (periph_irq_status[ST_SUSP] && suspend_irq_en)
		|| (periph_irq_status[ST_RESUME] && resume_irq_en);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sus_cnt_q <= 20'h0;
		end else if (!suspended || regulator_susp) begin
			// Deep sleep has no dwell
			sus_cnt_q <= 20'h0;
		end else begin
			sus_cnt_q <= sus_cnt_q + 20'h1;
		end
	end
	property p_irq_rise;
		$rose(periph_irq_status[ST_SUSP]) && suspend_irq_en |=> irq_out;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("suspend irq missing");
	property p_irq_cause;
		irq_out |-> irq_src || $past(irq_src);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
	property p_sticky;
		periph_irq_status[ST_RESUME] && !status_clr[ST_RESUME] |=> periph_irq_status[ST_RESUME];
	endproperty
	a_sticky: assert property (p_sticky) else $error("resume flag lost");
	property p_k_wait;
		$fell(send_resume) |-> !bus_k_drive [*8];
	endproperty
	a_k_wait: assert property (p_k_wait) else $error("K driven too early");
	property p_lock;
		$rose(osc_pll_en) && !por_reset && !$past(por_reset) |=> !periph_clk_en [*8];
	endproperty
	a_lock: assert property (p_lock) else $error("clock before lock");
	property p_dwell;
		suspended && !regulator_susp && !osc_pll_en && sus_cnt_q < DWELL_CYC - 4
			|=> !osc_pll_en;
	endproperty
	a_dwell: assert property (p_dwell) else $error("woke inside dwell");
	property p_por;
		por_reset |-> !periph_clk_en && !host_clk_en;
	endproperty
	a_por: assert property (p_por) else $error("clock during internal reset");
	property p_reg_off;
		!regulator_power_on && !por_reset |-> ##[1:4] !regulator_en;
	endproperty
	a_reg_off: assert property (p_reg_off) else $error("regulator stays on");
	property p_deep;
		regulator_susp |-> !periph_clk_en && !host_clk_en;
	endproperty
	a_deep: assert property (p_deep) else $error("clock in deep sleep");
	property p_wp;
		write_protect && !unlock_cmd |=> write_protect;
	endproperty
	a_wp: assert property (p_wp) else $error("protection dropped");
	c_kdrv: cover property (bus_k_drive);
	c_wp: cover property (write_protect);
	c_deep: cover property (regulator_susp);
endmodule
bind usb_suspend_resume_power_ctrl pwr_seq_chk #(.DWELL_CYC(DWELL_CYC)) chk_u (
	.clk, .rst_n, .send_resume, .suspend_irq_en, .resume_irq_en, .regulator_power_on,
	.unlock_cmd, .status_clr, .periph_irq_status, .irq_out, .bus_k_drive, .osc_pll_en,
	.periph_clk_en, .host_clk_en, .regulator_en, .regulator_susp, .por_reset,
	.suspended, .write_protect);
`default_nettype wire

// ---- dv/test_usb_suspend_resume_power_ctrl.sv ----
// Self-checking bench for the power sequencer with a host stand-in.
// Assumes short counts handed to the design parameters below.
`timescale 1ns/1ps
`default_nettype none
module test_usb_suspend_resume_power_ctrl;
	import pwr_seq_pkg::*;
	localparam int IC = 40;
	localparam int DC = 30;
	localparam int RC = 60;
	localparam int LC = 10;
	localparam int PC = 20;
	localparam int DL = 20;
	localparam int KC = 40;
	logic        clk, rst_n, sof_on, act_on, k_on, sof_seen, bus_activity, bus_k_state;
	logic        chip_select_n, read_strobe_n, ref_freq_sel_a, ref_freq_sel_b;
	logic        downstream_wake, vbus_overcurrent, go_suspend, send_resume;
	logic        chip_select_wake_en, suspend_irq_en, resume_irq_en, regulator_power_on;
	logic        regulator_suspend_power, unlock_cmd, irq_out, bus_k_drive, osc_pll_en;
	logic        periph_clk_en, host_clk_en, regulator_en, regulator_susp, por_reset;
	logic        suspended, write_protect;
	logic [1:0]  status_clr, periph_irq_status, ref_select;
	logic [15:0] k_len;
	int          mismatches, total_checks, cyc;
	logic [1:0]  ref_exp [4] = '{REF_SEL_12M, REF_SEL_19M2, REF_SEL_24M, REF_SEL_24M};
	host_model host_u (.clk, .rst_n, .sof_on, .act_on, .k_on, .bus_k_drive,
		.sof_seen, .bus_activity, .bus_k_state, .k_len);
	usb_suspend_resume_power_ctrl #(.IDLE_CYC(IC), .DWELL_CYC(DC), .RESUM_CYC(RC),
		.RDLY_CYC(DL), .RK_CYC(KC), .LOCK_CYC(LC), .PORP_CYC(PC)) dut_u (
		.clk, .rst_n, .sof_seen, .bus_activity, .bus_k_state, .chip_select_n,
		.read_strobe_n, .ref_freq_sel_a, .ref_freq_sel_b, .downstream_wake,
		.vbus_overcurrent, .go_suspend, .send_resume, .chip_select_wake_en,
		.suspend_irq_en, .resume_irq_en, .regulator_power_on,
		.regulator_suspend_power, .unlock_cmd, .status_clr, .periph_irq_status,
		.irq_out, .bus_k_drive, .osc_pll_en, .periph_clk_en, .host_clk_en,
		.regulator_en, .regulator_susp, .por_reset, .suspended, .write_protect,
		.ref_select);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Generous ceiling: the sequence needs about 740 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Both strobes low together for three cycles
	task automatic dummy_read();
		chip_select_n = 1'b0;
		read_strobe_n = 1'b0;
		wt(3);
		chip_select_n = 1'b1;
		read_strobe_n = 1'b1;
	endtask
	task automatic act_pulse();
		act_on = 1'b1;
		wt(1);
		act_on = 1'b0;
	endtask
	task automatic clr(input logic [1:0] v);
		status_clr = v;
		wt(1);
		status_clr = 2'h0;
		wt(2);
	endtask
	initial begin
		{act_on, k_on, ref_freq_sel_a, ref_freq_sel_b, downstream_wake} = '0;
		{vbus_overcurrent, go_suspend, send_resume, chip_select_wake_en} = '0;
		{suspend_irq_en, resume_irq_en, regulator_suspend_power, unlock_cmd} = '0;
		{chip_select_n, read_strobe_n, regulator_power_on, sof_on} = '1;
		status_clr = 2'h0;
		rst_n = 1'b0;
		wt(5);
		chk({por_reset, regulator_en, periph_clk_en}, 3'h4);
		rst_n = 1'b1;
		wt(4);
		chk(regulator_en, 1'b0);
		dummy_read();
		wt(3);
		chk({por_reset, periph_clk_en}, 2'h2);
		wt(PC + 6);
		chk({por_reset, regulator_en, periph_clk_en}, 3'h3);
		$display("power-up test done");
		sof_on = 1'b0;
		wt(IC - 10);
		act_pulse();
		wt(IC - 10);
		chk(periph_irq_status, 2'h0);
		wt(16);
		chk({periph_irq_status, irq_out}, 3'h2);
		clr(2'h1);
		chk(periph_irq_status, 2'h0);
		suspend_irq_en = 1'b1;
		act_pulse();
		wt(IC + 6);
		chk({periph_irq_status, irq_out}, 3'h3);
		clr(2'h1);
		chk(irq_out, 1'b0);
		$display("idle test done");
		go_suspend = 1'b1;
		wt(2);
		go_suspend = 1'b0;
		wt(3);
		chk(suspended, 1'b1);
		k_on = 1'b1;
		wt(4);
		k_on = 1'b0;
		wt(DC - 12);
		chk(suspended, 1'b1);
		wt(10);
		dummy_read();
		wt(4);
		chk({suspended, osc_pll_en}, 2'h2);
		chip_select_wake_en = 1'b1;
		resume_irq_en = 1'b1;
		dummy_read();
		wt(4);
		chk({osc_pll_en, periph_clk_en}, 2'h2);
		chk({periph_irq_status, irq_out}, 3'h5);
		chk(write_protect, 1'b1);
		wt(LC + 2);
		chk({periph_clk_en, suspended}, 2'h3);
		wt(RC - 10);
		chk(suspended, 1'b0);
		sof_on = 1'b1;
		unlock_cmd = 1'b1;
		wt(1);
		unlock_cmd = 1'b0;
		wt(2);
		chk(write_protect, 1'b0);
		clr(2'h2);
		$display("suspend test done");
		send_resume = 1'b1;
		wt(2);
		send_resume = 1'b0;
		wt(DL - 3);
		chk(bus_k_drive, 1'b0);
		wt(8);
		chk(bus_k_drive, 1'b1);
		wt(KC + 5);
		chk(k_len >= KC - 2 && k_len <= KC + 2, 1'b1);
		for (int i = 0; i < 4; i++) begin
			{ref_freq_sel_b, ref_freq_sel_a} = 2'(i);
			wt(4);
			chk(ref_select, ref_exp[i]);
		end
		$display("remote wake and reference test done");
		for (int s = 0; s < 4; s++) begin
			regulator_suspend_power = 1'b1;
			wt(5);
			chk({regulator_susp, periph_clk_en, host_clk_en}, 3'h4);
			downstream_wake = (s == 0);
			vbus_overcurrent = (s == 1);
			k_on = (s == 2);
			if (s == 3) begin
				dummy_read();
			end else begin
				wt(3);
			end
			{downstream_wake, vbus_overcurrent, k_on, regulator_suspend_power} = '0;
			wt(LC + 4);
			chk({regulator_susp, periph_clk_en}, 2'h1);
			wt(RC);
		end
		// Deep sleep entered from peripheral suspend
		go_suspend = 1'b1;
		wt(2);
		go_suspend = 1'b0;
		wt(3);
		regulator_suspend_power = 1'b1;
		wt(5);
		chk({regulator_susp, suspended, host_clk_en}, 3'h6);
		regulator_suspend_power = 1'b0;
		downstream_wake = 1'b1;
		wt(3);
		downstream_wake = 1'b0;
		wt(LC + 4);
		chk({regulator_susp, periph_clk_en}, 2'h1);
		regulator_power_on = 1'b0;
		wt(4);
		chk({regulator_en, periph_clk_en, host_clk_en}, 3'h0);
		$display("low-power test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
